// file: ccsc_clock_control.sv
// Clock source select controller: config register, delay sequencing,
// crystal pin control. Assumes synchronous I/O writes/reads and a
// separate detector reporting external oscillator stability.
// Reset causes arrive as levels or one-cycle pulses on ref_clk.
// Delay figures are counted in ref_clk cycles, not on the new source.
// The long resume delay is 400000 cycles; benches prefer the short one.
`timescale 1ns/100ps
module ccsc_clock_control (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// I/O register port
	input  wire logic        io_wr,
	input  wire logic [7:0]  io_addr,
	input  wire logic [7:0]  io_wdata,
	output logic [7:0]       io_rdata,
	// Reset causes and supply state
	input  wire logic        brown_out_reset,
	input  wire logic        low_voltage_reset,
	input  wire logic        watchdog_reset,
	input  wire logic        supply_low,
	// Suspend, wake and oscillator status
	input  wire logic        suspend_req,
	input  wire logic        wake_event,
	input  wire logic        ext_osc_stable,
	input  wire logic        wake_irq_global_en,
	// Internal clock and crystal pins
	input  wire logic        int_osc_clk,
	input  wire logic        crystal_in_pin,
	output logic             crystal_out_pin,
	output logic             crystal_in_pull_down,
	output logic             aux_port_bit_one,
	// Oscillator and clock enables
	output logic             int_osc_enable,
	output logic             ext_osc_enable,
	output logic             ext_mode,
	output logic             cpu_clk_en,
	output logic             chip_clk_en,
	// Configuration fields passed out
	output logic             usb_tune_enable,
	output logic             lvr_enable,
	output logic [2:0]       wake_timer_adjust,
	output logic             wake_timer_irq_en,
	// Restart after a supply hold
	output logic             fetch_from_vector,
	output logic [15:0]      fetch_address
);
	import ccsc_pkg::*;

	// Stored configuration and the clock source in use
	logic [7:0]            cfg;
	logic                  mode_ext;

	// Crystal-in level as seen on the port bit
	logic                  xin_sample;

	// Sequencer state and its next value
	ccsc_state_t           state;
	ccsc_state_t           next_state;

	// Delay counter handshake
	logic                  cnt_load;
	logic [CCSC_CNT_W-1:0] cnt_value;
	logic                  cnt_done;

	// Register hit and write strobe; the block owns a single address,
	// so every other address reads back as zero
	wire cfg_hit   = (io_addr == CCSC_CFG_ADDR);
	wire cfg_wr    = io_wr && cfg_hit;

	// Power-class resets: brown-out always counts, low voltage only while
	// the disable bit is clear
	wire bor_hit   = brown_out_reset;
	wire lvr_hit   = low_voltage_reset && lvr_enable;
	wire power_rst = bor_hit || lvr_hit;

	// Supply dip seen while running; the disable bit masks it
	wire lvr_trip  = !cfg[CCSC_BIT_LVR_DIS] && supply_low;

	// Decoded sequencer states, shared by the logic below
	wire in_run    = (state == CCSC_RUN);
	wire in_settle = (state == CCSC_SETTLE);
	wire in_wait   = (state == CCSC_WAIT_STABLE);
	wire in_susp   = (state == CCSC_SUSP);

	// Switch request: bit 0 written high from internal mode while running.
	// A watchdog or supply dip in the same cycle drops it. A watchdog also
	// loses the write, but a dip still stores it, so bit 0 reads high while the mode stays internal.
	wire wr_ext    = io_wdata[CCSC_BIT_EXT_EN];
	wire ext_start = cfg_wr && wr_ext && !mode_ext && in_run
	                 && !watchdog_reset && !lvr_trip;

	// Wake from suspend; the stored bit 0 picks the new source
	wire wake_now  = in_susp && wake_event;
	wire wake_ext  = wake_now && cfg[CCSC_BIT_EXT_EN];

	// Resume delay picked by bit 7; it only applies to the external source
	wire [CCSC_CNT_W-1:0] ext_delay = cfg[CCSC_BIT_RES_DLY]
	    ? CCSC_CNT_W'(CCSC_LONG_CYC)
	    : CCSC_CNT_W'(CCSC_SHORT_CYC);

	// Watchdog image of the register: only the enable bit is cleared,
	// every other field keeps what firmware wrote
	wire [7:0] cfg_wdr_mask  = ~(8'h01 << CCSC_BIT_EXT_EN);
	wire [7:0] cfg_after_wdr = cfg & cfg_wdr_mask;

	// Configuration register. Power reset beats watchdog, which beats
	// a write in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (rst || power_rst)
			cfg <= CCSC_CFG_RESET;
		else if (watchdog_reset)
			cfg <= cfg_after_wdr;
		else if (cfg_wr)
			cfg <= io_wdata;
	end

	// Clock mode. It goes external on a switch request or at a wake with bit 0 set,
	// and is chosen again only at wake, so clearing bit 0 while external does nothing
	// until the next wake. Power resets always fall back to internal.
	always_ff @(posedge ref_clk) begin
		if (rst || power_rst)
			mode_ext <= 1'b0;
		else if (ext_start)
			mode_ext <= 1'b1;
		else if (wake_now)
			mode_ext <= cfg[CCSC_BIT_EXT_EN];
	end

	// Delay sequencer. The counter stands in for a count kept on the newly
	// selected oscillator; counting ref_clk instead keeps one clock domain
	// at the cost of fixed cycle figures.
	always_comb begin
		next_state = state;
		cnt_load   = 1'b0;
		cnt_value  = '0;
		case (state)
			// Normal run: supply dip first, then switch, then suspend
			CCSC_RUN: begin
				if (lvr_trip) begin
					next_state = CCSC_SETTLE;
					cnt_load   = 1'b1;
					cnt_value  = CCSC_CNT_W'(CCSC_SETTLE_CYC);
				end else if (ext_start) begin
					next_state = CCSC_WAIT_STABLE;
				end else if (suspend_req) begin
					next_state = CCSC_SUSP;
				end
			end
			// Partial suspend while the supply settles
			CCSC_SETTLE: begin
				if (cnt_done)
					next_state = CCSC_RUN;
			end
			// All clocks held until the external oscillator is stable;
			// no limit here, a dead resonator keeps the part halted
			CCSC_WAIT_STABLE: begin
				if (ext_osc_stable) begin
					next_state = CCSC_DELAY;
					cnt_load   = 1'b1;
					cnt_value  = ext_delay;
				end
			end
			// Chip clocks run, processor still held for the resume delay
			CCSC_DELAY: begin
				if (cnt_done)
					next_state = CCSC_RUN;
			end
			// Wake picks the path: external waits for stability first,
			// internal only needs its short fixed start time
			CCSC_SUSP: begin
				if (wake_ext) begin
					next_state = CCSC_WAIT_STABLE;
				end else if (wake_now) begin
					next_state = CCSC_DELAY;
					cnt_load   = 1'b1;
					cnt_value  = CCSC_CNT_W'(CCSC_INT_WAKE_CYC);
				end
			end
			default: begin
				next_state = CCSC_RUN;
			end
		endcase
	end

	// Power resets restart with the supply settle hold, from any state,
	// so a brown-out during suspend or a switch still ends in settle
	always_ff @(posedge ref_clk) begin
		if (rst)
			state <= CCSC_RUN;
		else if (power_rst)
			state <= CCSC_SETTLE;
		else
			state <= next_state;
	end

	// Power reset needs a counter load the sequencer cannot give, since
	// the state register jumps to settle without passing through RUN
	wire                  load_any  = cnt_load || power_rst;
	wire [CCSC_CNT_W-1:0] load_val  = power_rst
	    ? CCSC_CNT_W'(CCSC_SETTLE_CYC) : cnt_value;

	// Shared delay counter; only one delay runs at a time
	ccsc_delay_counter u_delay (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.load       (load_any),
		.load_value (load_val),
		.done       (cnt_done)
	);

	// Crystal-in read as a port bit in internal mode only. The sample
	// goes nowhere else, so it can never raise an interrupt.
	wire xin_gpio = crystal_in_pin && !mode_ext;

	always_ff @(posedge ref_clk) begin
		if (rst)
			xin_sample <= 1'b0;
		else
			xin_sample <= xin_gpio;
	end

	// Read back the whole register; other addresses return zero.
	// The answer stands one cycle after the address is presented.
	always_ff @(posedge ref_clk) begin
		if (rst)
			io_rdata <= 8'h00;
		else
			io_rdata <= cfg_hit ? cfg : 8'h00;
	end

	// Clock gating levels taken from the sequencer state
	wire running    = in_run;
	wire halted_ext = in_wait;
	wire osc_off    = in_susp;

	// Crystal-out: internal clock, held high by bit 1, low when external.
	// Bit 1 is ignored in external mode so the pin never toggles there.
	wire clkout_hold = cfg[CCSC_BIT_CLKOUT_DIS];
	wire clkout_int  = clkout_hold ? 1'b1 : int_osc_clk;
	assign crystal_out_pin = mode_ext ? 1'b0 : clkout_int;

	// Crystal-in is a pulled-down input only in internal mode;
	// in external mode the pin belongs to the resonator
	assign crystal_in_pull_down = !mode_ext;
	assign aux_port_bit_one     = xin_sample;

	// One oscillator at a time; suspend stops both, and the mode
	// bit decides which one restarts at wake
	assign int_osc_enable       = !mode_ext && !osc_off;
	assign ext_osc_enable       = mode_ext && !osc_off;
	assign ext_mode             = mode_ext;

	// Processor waits out every delay; chip clocks only wait for
	// the external oscillator to become stable
	assign cpu_clk_en           = running;
	assign chip_clk_en          = !halted_ext && !osc_off;

	// Tuning request is masked in external mode, where the internal
	// clock is stopped and tuning would mean nothing
	assign usb_tune_enable      = cfg[CCSC_BIT_PREC] && !mode_ext;

	// Low-voltage reset enable is the inverse of the disable bit;
	// clearing it leaves the part exposed to supply dips
	assign lvr_enable           = !cfg[CCSC_BIT_LVR_DIS];

	// Wake timer period field and its interrupt gate; the timer
	// itself lives outside this block
	assign wake_timer_adjust    = cfg[CCSC_WAKE_ADJ_HI:CCSC_WAKE_ADJ_LO];
	assign wake_timer_irq_en    = wake_irq_global_en;

	// Settle hold ends with a fetch from the reset vector,
	// flagged in its last cycle
	assign fetch_from_vector    = in_settle && cnt_done;
	assign fetch_address        = CCSC_RESET_VECTOR;
endmodule : ccsc_clock_control

// file: ccsc_pkg.sv
// Constants for the clock source select control block.
// Assumes a single 100 MHz ref_clk domain and an 8-bit I/O write port.
package ccsc_pkg;
	localparam logic [7:0] CCSC_CFG_ADDR      = 8'hf8;
	localparam logic [7:0] CCSC_CFG_RESET     = 8'h00;
	localparam int         CCSC_BIT_RES_DLY   = 7;
	localparam int         CCSC_WAKE_ADJ_HI   = 6;
	localparam int         CCSC_WAKE_ADJ_LO   = 4;
	localparam int         CCSC_BIT_LVR_DIS   = 3;
	localparam int         CCSC_BIT_PREC      = 2;
	localparam int         CCSC_BIT_CLKOUT_DIS = 1;
	localparam int         CCSC_BIT_EXT_EN    = 0;
	localparam int         CCSC_CLK_MHZ       = 100;
	localparam int         CCSC_LONG_US       = 4000;
	localparam int         CCSC_SHORT_US      = 128;
	localparam int         CCSC_INT_WAKE_US   = 9;
	localparam int         CCSC_SETTLE_US     = 24;
	localparam int         CCSC_LONG_CYC      = CCSC_LONG_US * CCSC_CLK_MHZ;
	localparam int         CCSC_SHORT_CYC     = CCSC_SHORT_US * CCSC_CLK_MHZ;
	localparam int         CCSC_INT_WAKE_CYC  = CCSC_INT_WAKE_US * CCSC_CLK_MHZ;
	localparam int         CCSC_SETTLE_CYC    = CCSC_SETTLE_US * CCSC_CLK_MHZ;
	localparam int         CCSC_CNT_W         = 20;
	localparam logic [15:0] CCSC_RESET_VECTOR = 16'h0000;
	typedef enum logic [2:0] {
		CCSC_RUN, CCSC_SETTLE, CCSC_WAIT_STABLE, CCSC_DELAY, CCSC_SUSP
	} ccsc_state_t;
endpackage : ccsc_pkg

// file: ccsc_delay_counter.sv
// Down counter that times start-up and resume delays.
// Assumes load and count come from the controller in the same clock.
`timescale 1ns/100ps
module ccsc_delay_counter (
	input  wire logic                            ref_clk,
	input  wire logic                            rst,
	input  wire logic                            load,
	input  wire logic [ccsc_pkg::CCSC_CNT_W-1:0] load_value,
	output logic                                 done
);
	import ccsc_pkg::*;
	logic [CCSC_CNT_W-1:0] count;
	wire                   at_zero = (count == '0);

	// Load wins over counting so a fresh delay never inherits old time
	always_ff @(posedge ref_clk) begin
		if (rst)
			count <= '0;
		else if (load)
			count <= load_value;
		else if (!at_zero)
			count <= count - 1'b1;
	end

	assign done = at_zero && !load;
endmodule : ccsc_delay_counter

// file: ccsc_checker.sv
// Port checker for the clock source controller.
// Assumes one ref_clk domain and rst synchronous, active high.
`timescale 1ns/100ps
module ccsc_checker (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       io_wr,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic       brown_out_reset,
	input wire logic       low_voltage_reset,
	input wire logic       watchdog_reset,
	input wire logic       supply_low,
	input wire logic       wake_event,
	input wire logic       crystal_in_pull_down,
	input wire logic       ext_mode,
	input wire logic       cpu_clk_en,
	input wire logic       chip_clk_en,
	input wire logic       ext_osc_enable,
	input wire logic       usb_tune_enable,
	input wire logic       lvr_enable,
	input wire logic [2:0] wake_timer_adjust,
	input wire logic       fetch_from_vector
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [19:0] hold_cnt;
	// Halt length once chip clocks run; too long for a repetition
	always_ff @(posedge ref_clk) begin
		if (rst || cpu_clk_en || !chip_clk_en) hold_cnt <= 20'h0_0000;
		else hold_cnt <= hold_cnt + 20'h0_0001;
	end
	// Register write with no reset source competing
	sequence s_cfg_wr;
		io_wr && io_addr == 8'hf8 && !watchdog_reset && !brown_out_reset
			&& !low_voltage_reset && !supply_low;
	endsequence
	sequence s_halted;
		!cpu_clk_en && !chip_clk_en && ext_osc_enable;
	endsequence
	a_cfg_fields: assert property (s_cfg_wr |=>
		lvr_enable == !$past(io_wdata[3])
		&& wake_timer_adjust == $past(io_wdata[6:4])) else $error("cfg fields");
	a_tune_internal: assert property (usb_tune_enable |-> !ext_mode)
		else $error("tune in ext mode");
	a_pull_down: assert property (crystal_in_pull_down == !ext_mode)
		else $error("pull-down mode");
	a_switch_halt: assert property ($rose(ext_mode) |-> s_halted)
		else $error("switch not halted");
	a_delay_min: assert property ($rose(cpu_clk_en) && ext_mode
		|-> hold_cnt >= 20'h0_31f6) else $error("resume delay short");
	a_stay_ext: assert property (ext_mode && !wake_event
		&& !brown_out_reset && !low_voltage_reset && !supply_low |=> ext_mode)
		else $error("left ext mode");
	a_wdr_mode: assert property (watchdog_reset && !wake_event
		&& !brown_out_reset && !low_voltage_reset && !supply_low
		|=> $stable(ext_mode)) else $error("watchdog changed mode");
	a_bor_settle: assert property (brown_out_reset |=>
		!ext_mode && !cpu_clk_en && !ext_osc_enable) else $error("bor");
	a_fetch_vector: assert property (fetch_from_vector && !brown_out_reset
		&& !low_voltage_reset |=> cpu_clk_en) else $error("no restart");
endmodule : ccsc_checker
bind ccsc_clock_control ccsc_checker chk_u (.ref_clk, .rst, .io_wr,
	.io_addr, .io_wdata, .brown_out_reset, .low_voltage_reset,
	.watchdog_reset, .supply_low, .wake_event, .crystal_in_pull_down,
	.ext_mode, .cpu_clk_en, .chip_clk_en, .ext_osc_enable,
	.usb_tune_enable, .lvr_enable, .wake_timer_adjust, .fetch_from_vector);

// file: ccsc_osc_model.sv
// External resonator model on the crystal pins.
// Assumes it is sampled on ref_clk; stability lags enable by START_CYC.
`timescale 1ns/100ps
module ccsc_osc_model #(
	parameter int START_CYC = 50
) (
	input  wire logic ref_clk,
	input  wire logic ext_osc_enable,
	input  wire logic gpio_level,
	output logic      ext_osc_stable,
	output logic      crystal_in_pin
);
	int   run_cnt = 0;
	logic osc_q   = 1'b0;
	// Start-up restarts whenever the oscillator is switched off
	always @(posedge ref_clk) begin
		run_cnt <= ext_osc_enable ? run_cnt + 1 : 0;
		osc_q   <= ext_osc_enable ? ~osc_q : 1'b0;
	end
	assign ext_osc_stable = run_cnt >= START_CYC;
	// Clock on crystal-in, crystal-out left open
	assign crystal_in_pin = ext_osc_enable ? osc_q : gpio_level;
endmodule : ccsc_osc_model

// file: tb_top.sv
// Self-checking bench for the clock source controller.
// Assumes package, design, checker and oscillator model compiled first.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_top;
	import ccsc_pkg::*;
	localparam int SC = 50;
	logic        ref_clk, rst, io_wr, brown_out_reset, low_voltage_reset;
	logic        watchdog_reset, supply_low, suspend_req, wake_event;
	logic        ext_osc_stable, wake_irq_global_en, int_osc_clk;
	logic        crystal_in_pin, crystal_in_pull_down, aux_port_bit_one;
	logic        ext_osc_enable, ext_mode, cpu_clk_en, usb_tune_enable;
	logic        lvr_enable, chk_pend, gpio_lvl, crystal_out_pin;
	logic [7:0]  io_addr, io_wdata, io_rdata, d;
	logic [31:0] note_q[$], note;
	int          err_total, n_tests, cyc, lo, hi, low_cnt, last_low;
	wire  [15:0] probe = {io_rdata, ext_mode, cpu_clk_en, crystal_in_pull_down,
		aux_port_bit_one, lvr_enable, usb_tune_enable, ext_osc_enable,
		last_low >= lo && last_low <= hi};
	ccsc_clock_control dut_u (.ref_clk, .rst, .io_wr, .io_addr, .io_wdata,
		.io_rdata, .brown_out_reset, .low_voltage_reset, .watchdog_reset,
		.supply_low, .suspend_req, .wake_event, .ext_osc_stable,
		.wake_irq_global_en, .int_osc_clk, .crystal_in_pin, .crystal_out_pin,
		.crystal_in_pull_down, .aux_port_bit_one, .int_osc_enable(),
		.ext_osc_enable, .ext_mode, .cpu_clk_en, .chip_clk_en(),
		.usb_tune_enable, .lvr_enable, .wake_timer_adjust(),
		.wake_timer_irq_en(), .fetch_from_vector(), .fetch_address());
	ccsc_osc_model #(.START_CYC(SC)) osc_u (.ref_clk, .ext_osc_enable,
		.gpio_level(gpio_lvl), .ext_osc_stable, .crystal_in_pin);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic close_out;
		$display("Checks %0d, errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	// Watcher: halt length, then oldest note against the outputs
	always @(negedge ref_clk) begin
		if (cpu_clk_en === 1'b1 && low_cnt != 0) last_low = low_cnt;
		low_cnt = (cpu_clk_en === 1'b1) ? 0 : low_cnt + 1;
		if (chk_pend) begin
			note = note_q.pop_front();
			`CHK("probe", note[31:16], probe & note[15:0])
		end
	end
	// Free inputs and hang limit; run needs about 16200 cycles
	always @(negedge ref_clk) begin
		int_osc_clk = ~int_osc_clk;
		wake_irq_global_en = 1'($urandom);
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			close_out();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		io_wr = 1'b1;
		io_addr = a;
		io_wdata = v;
		tick(1);
		io_wr = 1'b0;
	endtask : wr
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic check(input logic [7:0] a, input logic [15:0] ex, m);
		io_addr = a;
		note_q.push_back({ex & m, m});
		chk_pend <= 1'b1;
		tick(1);
		chk_pend <= 1'b0;
		tick(1);
	endtask : check
	// Hold-off window, then wait for the processor to restart
	task automatic wait_cpu(input int l, input int h);
		lo = l;
		hi = h;
		tick(1);
		while (cpu_clk_en !== 1'b1) tick(1);
		tick(1);
	endtask : wait_cpu
	initial begin
		rst = 1'b1;
		{io_wr, brown_out_reset, low_voltage_reset, watchdog_reset} = '0;
		{supply_low, suspend_req, wake_event, chk_pend, gpio_lvl} = '0;
		{int_osc_clk, wake_irq_global_en, io_addr, io_wdata} = '0;
		void'($urandom(63));
		tick(6);
		rst = 1'b0;
		check(CCSC_CFG_ADDR, 16'h0068, 16'hffee);
		repeat (4) begin
			d = 8'($urandom) & 8'hfe;
			gpio_lvl = 1'($urandom);
			wr(CCSC_CFG_ADDR, d);
			check(CCSC_CFG_ADDR, {d, 3'b011, gpio_lvl, ~d[3], d[2], 2'b00},
				16'hfffe);
			@(posedge ref_clk);
			`CHK("clk_out", d[1] | int_osc_clk, crystal_out_pin)
			tick(1);
		end
		check(8'h26, 16'h0000, 16'hff00);
		wr(CCSC_CFG_ADDR, 8'h01);
		check(CCSC_CFG_ADDR, 16'h018a, 16'hfffe);
		wait_cpu(CCSC_SHORT_CYC, CCSC_SHORT_CYC + SC + 20);
		check(CCSC_CFG_ADDR, 16'h01cb, 16'hffff);
		pulse(watchdog_reset);
		check(CCSC_CFG_ADDR, 16'h00c9, 16'hfffd);
		wr(CCSC_CFG_ADDR, 8'h04);
		check(CCSC_CFG_ADDR, 16'h04c9, 16'hfffd);
		pulse(suspend_req);
		pulse(wake_event);
		wait_cpu(CCSC_INT_WAKE_CYC, CCSC_INT_WAKE_CYC + 10);
		check(CCSC_CFG_ADDR, 16'h046d, 16'hffef);
		wr(CCSC_CFG_ADDR, 8'h81);
		tick(3);
		pulse(brown_out_reset);
		wait_cpu(CCSC_SETTLE_CYC, CCSC_SETTLE_CYC + 20);
		check(CCSC_CFG_ADDR, 16'h0069, 16'hffef);
		close_out();
	end
endmodule : tb_top
